// ---- logic/aem_pkg.sv ----
// Function
// - Data memory: 256 pages of 32 bytes
// - Scratchpad byte confirmed by CRC before programming
// - Separate status memory, own commands only
// - Page protect bits block data page writes
// - Redirection protect bits block redirection byte writes
// - Page-in-use flags never steer the logic
// - Redirection bytes never steer the logic
// - Programming only clears bits to zero
// - Unimplemented status reads FFH, writes ignored
// - Writes go one byte per programming pulse
// - All bits move least significant first
// - F0H streams data bytes to memory end
// - End-of-memory CRC over command, address, data
// - Ones after end-of-memory CRC until reset
// - Reset-aborted data read yields no CRC
// - Status read streams to page end, CRC
// - First status CRC covers command and address
// - Later status CRCs cover page data only
// - Ones after final status page CRC
// - Commands refused until ROM sequence completes
package aem_pkg;

    // Memory geometry
    localparam int unsigned DATA_PAGES = 256;
    localparam int unsigned PAGE_BYTES = 32;
    localparam int unsigned STAT_AW    = 9;

    // Command codes
    localparam logic [7:0]  CMD_READ_DATA   = 8'hF0;
    localparam logic [7:0]  CMD_READ_STAT   = 8'hAA;

    // Status memory map
    localparam logic [15:0] STAT_WP_BASE    = 16'h0000;
    localparam logic [15:0] STAT_RP_BASE    = 16'h0020;
    localparam logic [15:0] STAT_FLAG_BASE  = 16'h0040;
    localparam logic [15:0] STAT_GAP_BASE   = 16'h0060;
    localparam logic [15:0] STAT_REDIR_BASE = 16'h0100;
    localparam logic [15:0] STAT_END        = 16'h0200;
    localparam logic [15:0] STAT_LAST_PAGE  = 16'h01F8;
    localparam logic [2:0]  STAT_PAGE_LAST  = 3'h7;

    // Values and counts
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
    localparam logic [15:0] IDLE_LINE       = 16'hFFFF;
    localparam logic [15:0] CRC_INIT        = 16'h0000;
    localparam logic [15:0] CRC_POLY_REFL   = 16'hA001;
    localparam logic [3:0]  BYTE_LAST       = 4'h7;
    localparam logic [3:0]  WORD_LAST       = 4'hF;
    localparam logic [15:0] ADDR_STEP       = 16'h0001;

    typedef enum logic [2:0] {
        MODE_NONE, MODE_RD_DATA, MODE_RD_STAT, MODE_WR_DATA, MODE_WR_STAT
    } aem_mode_type;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_FETCH, ST_RD_DATA, ST_CRC_LD, ST_RD_CRC,
        ST_WR_DATA, ST_WR_PROG, ST_WR_VERIFY, ST_ONES
    } aem_state_type;

    // Control of the CRC generator
    typedef struct packed {
        logic        clr;
        logic        ld;
        logic        shift;
        logic        bit_in;
        logic [15:0] ld_val;
    } aem_crc_ctl_type;

endpackage

// ---- logic/aem_crc16.sv ----
module aem_crc16 (
    input  wire logic                    clk_i,    // System clock
    input  wire logic                    resetn_i, // Async reset, active low
    input  wire aem_pkg::aem_crc_ctl_type ctl_i,   // Clear, load, shift
    output logic [15:0]                  crc_o     // Current remainder
);

    // Reflected form, one bit per slot
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        logic [15:0] s;
        s = {1'b0, c[15:1]};
        if (c[0] ^ b) begin
            s = s ^ aem_pkg::CRC_POLY_REFL;
        end
        return s;
    endfunction

    // Clear beats load beats shift
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_o <= aem_pkg::CRC_INIT;
        end else if (ctl_i.clr) begin
            crc_o <= aem_pkg::CRC_INIT;
        end else if (ctl_i.ld) begin
            crc_o <= ctl_i.ld_val;
        end else if (ctl_i.shift) begin
            crc_o <= crc_step(crc_o, ctl_i.bit_in);
        end
    end

endmodule // aem_crc16

// ---- logic/aem_eprom.sv ----
module aem_eprom #(
    parameter int unsigned AW = 8 // Address width
) (
    input  wire logic          clk_i, // System clock
    input  wire logic [AW-1:0] ra_i,  // Read address, port A
    output logic [7:0]         qa_o,  // Read data, port A
    input  wire logic [AW-1:0] rb_i,  // Read address, port B
    output logic [7:0]         qb_o,  // Read data, port B
    input  wire logic          we_i,  // Program strobe
    input  wire logic [AW-1:0] wa_i,  // Program address
    input  wire logic [7:0]    wd_i   // Program pattern
);

    logic [7:0] mem [2**AW];

    // Unprogrammed cells read as ones
    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            mem[i] = aem_pkg::ERASED_BYTE;
        end
    end

    // Nonvolatile: no reset, and a zero can never come back
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[wa_i] <= mem[wa_i] & wd_i;
        end
    end

    assign qa_o = mem[ra_i];
    assign qb_o = mem[rb_i];

endmodule // aem_eprom

// ---- logic/aem_access.sv ----
module aem_access #(
    parameter int unsigned DATA_PAGES  = aem_pkg::DATA_PAGES, // Data memory pages
    parameter logic [7:0]  WR_DATA_CMD = 8'h3C,               // Write data command
    parameter logic [7:0]  WR_STAT_CMD = 8'h5A                // Write status command
) (
    input  wire logic clk_i,        // System clock, 10 MHz
    input  wire logic resetn_i,     // Async reset, active low
    input  wire logic bus_reset_i,  // Reset pulse seen on the line
    input  wire logic rom_done_i,   // ROM command sequence completed
    input  wire logic wslot_i,      // Write slot finished
    input  wire logic wbit_i,       // Bit of that write slot
    input  wire logic rslot_i,      // Read slot finished
    output logic      rbit_o,       // Bit for the next read slot
    input  wire logic prog_pulse_i, // Programming voltage applied
    output logic      armed_o,      // Memory commands accepted
    output logic      busy_o,       // Command in progress
    output logic      prog_block_o  // A programming attempt refused since the last line reset
);

    localparam int unsigned PB_W = $clog2(aem_pkg::PAGE_BYTES);
    localparam int unsigned DAW  = $clog2(DATA_PAGES * aem_pkg::PAGE_BYTES);
    localparam int unsigned SAW  = aem_pkg::STAT_AW;

    // Protect bitmaps hold at most 256 pages
    if (DATA_PAGES < 8 || DATA_PAGES > aem_pkg::DATA_PAGES ||
        (DATA_PAGES & (DATA_PAGES - 1)) != 0) begin : g_check
        $error("DATA_PAGES must be a power of two from 8 to 256");
    end

    aem_pkg::aem_state_type   state_q;
    aem_pkg::aem_state_type   state_d;
    aem_pkg::aem_mode_type    mode_q;
    aem_pkg::aem_crc_ctl_type crc_ctl;
    logic [3:0]               cnt_q;
    logic [15:0]              sh_q;
    logic [15:0]              addr_q;
    logic [15:0]              out_q;
    logic [7:0]               scratch_q;
    logic                     blocked_q;
    logic [15:0]              crc_val;
    logic [7:0]               dmem_q;
    logic [7:0]               smem_q;
    logic [7:0]               sprot_q;
    logic [7:0]               fetch_byte;
    logic [7:0]               rx_byte;
    logic [15:0]              rx_word;
    logic [15:0]              addr_inc;
    logic [7:0]               page;
    logic [SAW-1:0]           prot_idx;
    logic                     rx_ev;
    logic                     tx_ev;
    logic                     is_write;
    logic                     seg_end;
    logic                     stat_final;
    logic                     prog_ok;
    logic                     prog_en;

    // Command decode; unknown codes fall to MODE_NONE
    function automatic aem_pkg::aem_mode_type cmd_mode(input logic [7:0] c);
        if (c == aem_pkg::CMD_READ_DATA) begin
            return aem_pkg::MODE_RD_DATA;
        end else if (c == aem_pkg::CMD_READ_STAT) begin
            return aem_pkg::MODE_RD_STAT;
        end else if (c == WR_DATA_CMD) begin
            return aem_pkg::MODE_WR_DATA;
        end else if (c == WR_STAT_CMD) begin
            return aem_pkg::MODE_WR_STAT;
        end
        return aem_pkg::MODE_NONE;
    endfunction

    // Status cells that physically exist
    function automatic logic stat_impl(input logic [15:0] a);
        return (a < aem_pkg::STAT_GAP_BASE) ||
               (a >= aem_pkg::STAT_REDIR_BASE && a < aem_pkg::STAT_END);
    endfunction

    // Slot events only count in states that expect them
    assign rx_ev = wslot_i && (state_q == aem_pkg::ST_CMD ||
                               state_q == aem_pkg::ST_ADDR ||
                               state_q == aem_pkg::ST_WR_DATA);
    assign tx_ev = rslot_i && (state_q == aem_pkg::ST_RD_DATA ||
                               state_q == aem_pkg::ST_RD_CRC ||
                               state_q == aem_pkg::ST_WR_VERIFY);

    // Incoming bits enter at the top, so the first bit ends lowest
    assign rx_byte  = {wbit_i, sh_q[15:9]};
    assign rx_word  = {wbit_i, sh_q[15:1]};
    assign addr_inc = addr_q + aem_pkg::ADDR_STEP;
    assign is_write = (mode_q == aem_pkg::MODE_WR_DATA) ||
                      (mode_q == aem_pkg::MODE_WR_STAT);

    // Data field ends at its last byte, status pages at xx7 or xxF
    assign seg_end = (mode_q == aem_pkg::MODE_RD_DATA) ?
                     (&addr_q[DAW-1:0]) :
                     (addr_q[2:0] == aem_pkg::STAT_PAGE_LAST);
    assign stat_final = addr_q >= aem_pkg::STAT_LAST_PAGE;

    // Byte for the next read or verify
    always_comb begin
        if (mode_q == aem_pkg::MODE_RD_DATA || mode_q == aem_pkg::MODE_WR_DATA) begin
            fetch_byte = dmem_q;
        end else if (stat_impl(addr_q)) begin
            fetch_byte = smem_q;
        end else begin
            fetch_byte = aem_pkg::ERASED_BYTE;
        end
    end

    // Protect lookup: page protect for data, redirection protect for status
    always_comb begin
        if (mode_q == aem_pkg::MODE_WR_DATA) begin
            page     = 8'(addr_q[DAW-1:PB_W]);
            prot_idx = SAW'(aem_pkg::STAT_WP_BASE) + SAW'(page[7:3]);
        end else begin
            page     = addr_q[7:0];
            prot_idx = SAW'(aem_pkg::STAT_RP_BASE) + SAW'(page[7:3]);
        end
    end

    // A programmed (zero) bit protects; flag and redirection contents unused
    always_comb begin
        if (mode_q == aem_pkg::MODE_WR_DATA) begin
            prog_ok = sprot_q[page[2:0]];
        end else if (addr_q >= aem_pkg::STAT_REDIR_BASE && addr_q < aem_pkg::STAT_END) begin
            prog_ok = sprot_q[page[2:0]];
        end else begin
            prog_ok = stat_impl(addr_q);
        end
    end

    // One byte programmed per pulse, from the scratchpad
    assign prog_en = (state_q == aem_pkg::ST_WR_PROG) && prog_pulse_i &&
                     prog_ok && !bus_reset_i;

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            aem_pkg::ST_IDLE: begin
                if (rom_done_i) begin
                    state_d = aem_pkg::ST_CMD;
                end
            end
            aem_pkg::ST_CMD: begin
                if (wslot_i && cnt_q == aem_pkg::BYTE_LAST) begin
                    state_d = (cmd_mode(rx_byte) == aem_pkg::MODE_NONE) ?
                              aem_pkg::ST_ONES : aem_pkg::ST_ADDR;
                end
            end
            aem_pkg::ST_ADDR: begin
                if (wslot_i && cnt_q == aem_pkg::WORD_LAST) begin
                    state_d = is_write ? aem_pkg::ST_WR_DATA : aem_pkg::ST_FETCH;
                end
            end
            aem_pkg::ST_FETCH: begin
                state_d = is_write ? aem_pkg::ST_WR_VERIFY : aem_pkg::ST_RD_DATA;
            end
            aem_pkg::ST_RD_DATA: begin
                if (rslot_i && cnt_q == aem_pkg::BYTE_LAST) begin
                    state_d = seg_end ? aem_pkg::ST_CRC_LD : aem_pkg::ST_FETCH;
                end
            end
            aem_pkg::ST_CRC_LD: begin
                state_d = aem_pkg::ST_RD_CRC;
            end
            aem_pkg::ST_RD_CRC: begin
                if (rslot_i && cnt_q == aem_pkg::WORD_LAST) begin
                    if (is_write) begin
                        state_d = aem_pkg::ST_WR_PROG;
                    end else if (mode_q == aem_pkg::MODE_RD_DATA || stat_final) begin
                        state_d = aem_pkg::ST_ONES;
                    end else begin
                        state_d = aem_pkg::ST_FETCH;
                    end
                end
            end
            aem_pkg::ST_WR_DATA: begin
                if (wslot_i && cnt_q == aem_pkg::BYTE_LAST) begin
                    state_d = aem_pkg::ST_CRC_LD;
                end
            end
            aem_pkg::ST_WR_PROG: begin
                if (prog_pulse_i) begin
                    state_d = aem_pkg::ST_FETCH;
                end
            end
            aem_pkg::ST_WR_VERIFY: begin
                if (rslot_i && cnt_q == aem_pkg::BYTE_LAST) begin
                    state_d = aem_pkg::ST_WR_DATA;
                end
            end
            aem_pkg::ST_ONES: begin
                state_d = aem_pkg::ST_ONES;
            end
        endcase
    end

    // A reset pulse ends any sequence at once, mid-read reads get no CRC
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= aem_pkg::ST_IDLE;
        end else if (bus_reset_i) begin
            state_q <= aem_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Bit counter restarts on every state change
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
        end else if (bus_reset_i || state_d != state_q) begin
            cnt_q <= '0;
        end else if (rx_ev || tx_ev) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Command mode latched at the end of the command byte
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_q <= aem_pkg::MODE_NONE;
        end else if (bus_reset_i) begin
            mode_q <= aem_pkg::MODE_NONE;
        end else if (state_q == aem_pkg::ST_CMD && wslot_i &&
                     cnt_q == aem_pkg::BYTE_LAST) begin
            mode_q <= cmd_mode(rx_byte);
        end
    end

    // Receive shifter, least significant bit first
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sh_q <= '0;
        end else if (rx_ev) begin
            sh_q <= {wbit_i, sh_q[15:1]};
        end
    end

    // Address counter: loaded once, then walks through the field
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_q <= '0;
        end else if (state_q == aem_pkg::ST_ADDR && wslot_i &&
                     cnt_q == aem_pkg::WORD_LAST) begin
            addr_q <= rx_word;
        end else if (state_q == aem_pkg::ST_RD_DATA && rslot_i &&
                     cnt_q == aem_pkg::BYTE_LAST && !seg_end) begin
            addr_q <= addr_inc;
        end else if (state_q == aem_pkg::ST_RD_CRC && rslot_i &&
                     cnt_q == aem_pkg::WORD_LAST && state_d == aem_pkg::ST_FETCH) begin
            addr_q <= addr_inc;
        end else if (state_q == aem_pkg::ST_WR_VERIFY && rslot_i &&
                     cnt_q == aem_pkg::BYTE_LAST) begin
            addr_q <= addr_inc;
        end
    end

    // Scratchpad holds the byte until the pulse programs it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scratch_q <= aem_pkg::ERASED_BYTE;
        end else if (state_q == aem_pkg::ST_WR_DATA && wslot_i &&
                     cnt_q == aem_pkg::BYTE_LAST) begin
            scratch_q <= rx_byte;
        end
    end

    // Outgoing shifter refills with ones, so an idle line reads one
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_q <= aem_pkg::IDLE_LINE;
        end else if (bus_reset_i) begin
            out_q <= aem_pkg::IDLE_LINE;
        end else if (state_q == aem_pkg::ST_FETCH) begin
            out_q <= {aem_pkg::ERASED_BYTE, fetch_byte};
        end else if (state_q == aem_pkg::ST_CRC_LD) begin
            out_q <= crc_val;
        end else if (tx_ev) begin
            out_q <= {1'b1, out_q[15:1]};
        end
    end

    // Refused programming stays visible; a new refusal wins over the clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            blocked_q <= 1'b0;
        end else if (state_q == aem_pkg::ST_WR_PROG && prog_pulse_i && !prog_ok) begin
            blocked_q <= 1'b1;
        end else if (bus_reset_i) begin
            blocked_q <= 1'b0;
        end
    end

    // CRC: cleared per command and status page, fed by received bits and read data bits
    always_comb begin
        crc_ctl        = '0;
        crc_ctl.ld_val = addr_inc;
        crc_ctl.bit_in = wbit_i;
        if (state_q == aem_pkg::ST_IDLE && rom_done_i) begin
            crc_ctl.clr = 1'b1;
        end else if (rx_ev) begin
            crc_ctl.shift = 1'b1;
        end else if (tx_ev && state_q == aem_pkg::ST_RD_DATA) begin
            crc_ctl.shift  = 1'b1;
            crc_ctl.bit_in = out_q[0];
        end else if (state_q == aem_pkg::ST_RD_CRC && rslot_i &&
                     cnt_q == aem_pkg::WORD_LAST && state_d == aem_pkg::ST_FETCH) begin
            crc_ctl.clr = 1'b1;
        end else if (state_q == aem_pkg::ST_WR_VERIFY && rslot_i &&
                     cnt_q == aem_pkg::BYTE_LAST) begin
            crc_ctl.ld = 1'b1;
        end
    end

    aem_crc16 u_crc (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ctl_i    (crc_ctl),
        .crc_o    (crc_val)
    );

    // Main data field, reached only by the data commands
    aem_eprom #(
        .AW (DAW)
    ) u_data (
        .clk_i (clk_i),
        .ra_i  (addr_q[DAW-1:0]),
        .qa_o  (dmem_q),
        .rb_i  ('0),
        .qb_o  (),
        .we_i  (prog_en && mode_q == aem_pkg::MODE_WR_DATA),
        .wa_i  (addr_q[DAW-1:0]),
        .wd_i  (scratch_q)
    );

    // Status field, its own array; port B serves the protect lookup
    aem_eprom #(
        .AW (SAW)
    ) u_stat (
        .clk_i (clk_i),
        .ra_i  (addr_q[SAW-1:0]),
        .qa_o  (smem_q),
        .rb_i  (prot_idx),
        .qb_o  (sprot_q),
        .we_i  (prog_en && mode_q == aem_pkg::MODE_WR_STAT),
        .wa_i  (addr_q[SAW-1:0]),
        .wd_i  (scratch_q)
    );

    // Outputs
    assign rbit_o       = out_q[0];
    assign armed_o      = state_q != aem_pkg::ST_IDLE;
    assign busy_o       = state_q != aem_pkg::ST_IDLE && state_q != aem_pkg::ST_CMD;
    assign prog_block_o = blocked_q;

endmodule // aem_access

// ---- tb/aem_monitor.sv ----
module aem_monitor (
    input wire logic clk_i,        // Clock
    input wire logic resetn_i,     // Reset, low
    input wire logic bus_reset_i,  // Line reset
    input wire logic rom_done_i,   // Selection done
    input wire logic wslot_i,      // Write slot
    input wire logic wbit_i,       // Write bit
    input wire logic rslot_i,      // Read slot
    input wire logic rbit_o,       // Answer bit
    input wire logic prog_pulse_i, // Program level
    input wire logic armed_o,      // Armed
    input wire logic busy_o,       // Busy
    input wire logic prog_block_o  // Refused
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // Steps of a line reset
    sequence s_line_reset;
        bus_reset_i;
    endsequence
    sequence s_quiet;
        !armed_o && !busy_o && rbit_o;
    endsequence

    // Answer bit only moves after a slot, a fetch or a reset
    a_reset_quiets: assert property (s_line_reset |=> s_quiet)
        else $error("line reset did not idle the device");
    a_unarmed_ones: assert property (!armed_o |-> rbit_o)
        else $error("unselected device drove a zero");
    a_unarmed_idle: assert property (!armed_o |-> !busy_o)
        else $error("busy without selection");
    a_arm_on_done: assert property (rom_done_i && !armed_o && !bus_reset_i |=> armed_o)
        else $error("selection not taken");
    a_cmd_wait_high: assert property (armed_o && !busy_o |-> rbit_o)
        else $error("zero answered while waiting for command");
    a_busy_cause: assert property ($rose(busy_o) |-> $past(wslot_i) || $past(wslot_i, 2))
        else $error("busy rose without a command byte");
    a_rbit_stands: assert property ($changed(rbit_o) |->
        $past(rslot_i) || $past(rslot_i, 2)
        || $past(wslot_i) || $past(wslot_i, 2) || $past(bus_reset_i)
        || $past(prog_pulse_i) || $past(prog_pulse_i, 2))
        else $error("answer bit moved without cause");
    a_block_cause: assert property ($rose(prog_block_o) |->
        $past(prog_pulse_i) || $past(prog_pulse_i, 2))
        else $error("refusal without programming pulse");
    a_block_holds: assert property (prog_block_o && !prog_pulse_i
        && !$past(prog_pulse_i) && !bus_reset_i |=> prog_block_o)
        else $error("refusal flag dropped on its own");
endmodule // aem_monitor

bind aem_access aem_monitor u_aem_monitor (.clk_i(clk_i), .resetn_i(resetn_i),
    .bus_reset_i(bus_reset_i), .rom_done_i(rom_done_i), .wslot_i(wslot_i), .wbit_i(wbit_i),
    .rslot_i(rslot_i), .rbit_o(rbit_o), .prog_pulse_i(prog_pulse_i), .armed_o(armed_o),
    .busy_o(busy_o), .prog_block_o(prog_block_o));

// ---- tb/aem_master.sv ----
module aem_master (
    input  wire logic clk_i,        // Clock
    input  wire logic rbit_i,       // Device answer
    output logic      bus_reset_o,  // Line reset
    output logic      rom_done_o,   // Selection done
    output logic      wslot_o,      // Write slot
    output logic      wbit_o,       // Write bit
    output logic      rslot_o,      // Read slot
    output logic      prog_pulse_o  // Program level
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet line at time zero
    initial begin
        {bus_reset_o, rom_done_o, wslot_o, wbit_o, rslot_o, prog_pulse_o} = '0;
    end

    // One strobe, then two quiet cycles; released bit never echoes
    task automatic strobe(input int sel);
        @(negedge clk_i);
        case (sel)
            0: bus_reset_o = 1'b1;
            1: rom_done_o = 1'b1;
            2: wslot_o = 1'b1;
            3: rslot_o = 1'b1;
            default: prog_pulse_o = 1'b1;
        endcase
        @(negedge clk_i);
        {bus_reset_o, rom_done_o, wslot_o, rslot_o, prog_pulse_o} = '0;
        wbit_o = ~wbit_o;
        repeat (2) @(negedge clk_i);
    endtask

    task automatic wr_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            wbit_o = b[i];
            strobe(2);
        end
    endtask

    task automatic rd(input int n);
        repeat (n) strobe(3);
    endtask

    // Every command starts from a fresh line reset and ROM selection
    task automatic open_cmd(input logic [7:0] cmd, input logic [15:0] a);
        strobe(0);
        strobe(1);
        wr_byte(cmd);
        wr_byte(a[7:0]);
        wr_byte(a[15:8]);
    endtask
endmodule // aem_master

// ---- tb/aem_access_tb.sv ----
module aem_access_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, resetn_i, bus_reset, rom_done, wslot, wbit, rslot, rbit;
    logic        prog_pulse, armed, busy, prog_block, rbit_n;
    logic        exp_q[$];
    logic [7:0]  d1, d2;
    logic [15:0] crc;
    int          n_errors = 0;
    int          comparisons = 0;

    aem_access u_aem_access (.clk_i(clk_i), .resetn_i(resetn_i), .bus_reset_i(bus_reset),
        .rom_done_i(rom_done), .wslot_i(wslot), .wbit_i(wbit), .rslot_i(rslot), .rbit_o(rbit),
        .prog_pulse_i(prog_pulse), .armed_o(armed), .busy_o(busy), .prog_block_o(prog_block));
    aem_master u_aem_master (.clk_i(clk_i), .rbit_i(rbit), .bus_reset_o(bus_reset),
        .rom_done_o(rom_done), .wslot_o(wslot), .wbit_o(wbit), .rslot_o(rslot),
        .prog_pulse_o(prog_pulse));

    // Clock at 10 MHz
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic give_verdict;
        $display("n_errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reflected x16+x15+x2+1 from the bench's own arithmetic
    function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? 16'hA001 : 16'h0000);
        return c;
    endfunction

    // Answer as it stood before the edge
    always @(negedge clk_i) rbit_n = rbit;

    // Each read slot takes the oldest noted bit
    always @(posedge clk_i) begin
        if (rslot === 1'b1) begin
            if (exp_q.size() == 0) chk(8'h00, 8'h01);
            else chk({7'h00, rbit_n}, {7'h00, exp_q.pop_front()});
        end
    end

    task automatic rd(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) exp_q.push_back(v[i]);
        u_aem_master.rd(n);
    endtask

    task automatic rdb(input logic [7:0] b);
        rd({8'h00, b}, 8);
        crc = crc_add(crc, b);
    endtask

    task automatic start(input logic [7:0] cmd, input logic [15:0] a);
        u_aem_master.open_cmd(cmd, a);
        crc = crc_add(crc_add(crc_add(16'h0000, cmd), a[7:0]), a[15:8]);
    endtask

    // One programming pass: data, CRC, pulse, readback, refusal flag
    task automatic prog(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d,
                        input logic [7:0] back, input logic blk);
        start(cmd, a);
        u_aem_master.wr_byte(d);
        rd(crc_add(crc, d), 16);
        u_aem_master.strobe(4);
        rd({8'h00, back}, 8);
        chk({7'h00, prog_block}, {7'h00, blk});
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        n_errors++;
        give_verdict();
    end

    initial begin
        resetn_i = 1'b0;
        void'($urandom(84990));
        repeat (8) @(posedge clk_i);
        @(negedge clk_i) resetn_i = 1'b1;
        // Unselected device ignores a command
        u_aem_master.wr_byte(8'hF0);
        rd(16'hFFFF, 8);
        chk({7'h00, busy}, 8'h00);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        prog(8'h3C, 16'h1FFE, d1, d1, 1'b0);
        prog(8'h3C, 16'h1FFE, d2, d1 & d2, 1'b0);
        prog(8'h5A, 16'h001F, 8'h7F, 8'h7F, 1'b0);
        prog(8'h3C, 16'h1FFE, 8'h00, d1 & d2, 1'b1);
        prog(8'h5A, 16'h0060, 8'h00, 8'hFF, 1'b1);
        prog(8'h5A, 16'h003F, 8'h7F, 8'h7F, 1'b0);
        prog(8'h5A, 16'h01FF, 8'h00, 8'hFF, 1'b1);
        prog(8'h5A, 16'h005F, 8'h00, 8'h00, 1'b0);
        prog(8'h5A, 16'h01FE, 8'h00, 8'h00, 1'b0);
        prog(8'h3C, 16'h1FC0, d2, d2, 1'b0);
        // Next byte, CRC starts from the new address
        u_aem_master.wr_byte(d1);
        rd(crc_add(16'h1FC1, d1), 16);
        u_aem_master.strobe(4);
        rd({8'h00, d1}, 8);
        // Final status page, then ones
        start(8'hAA, 16'h01FE);
        rdb(8'h00);
        rdb(8'hFF);
        rd(crc, 16);
        rd(16'hFFFF, 16);
        // Page end, then a data-only page over the unimplemented gap
        start(8'hAA, 16'h005E);
        rdb(8'hFF);
        rdb(8'h00);
        rd(crc, 16);
        crc = 16'h0000;
        repeat (8) rdb(8'hFF);
        rd(crc, 16);
        // Data read to the end of memory
        start(8'hF0, 16'h1FFE);
        rdb(d1 & d2);
        rdb(8'hFF);
        rd(crc, 16);
        rd(16'hFFFF, 16);
        // Unknown command leaves only ones
        start(8'h55, 16'h0000);
        rd(16'hFFFF, 16);
        chk({7'h00, busy}, 8'h01);
        // Aborted read leaves only ones
        start(8'hF0, 16'h1000);
        rdb(8'hFF);
        u_aem_master.strobe(0);
        chk({7'h00, armed}, 8'h00);
        rd(16'hFFFF, 16);
        give_verdict();
    end
endmodule // aem_access_tb
